// ==== rtl/gw_regs.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 Modbus-to-HART variable gateway. Assumes a 25 MHz system clock.
*/
`ifndef GW_REGS_SVH
`define GW_REGS_SVH
`define GW_NVAR        6
`define GW_CTRL_OFS    9'h000
`define GW_MAP_OFS     9'h004
`define GW_ADDL_OFS    9'h008
`define GW_PV_OFS      9'h00c
`define GW_MB_OFS      9'h010
`define GW_UST_OFS     9'h014
`define GW_RESP_OFS    9'h018
`define GW_VAR_BASE    9'h040
`define GW_VAR_END     9'h100
`define GW_VF_CFG      3'h0
`define GW_VF_UNIT     3'h1
`define GW_VF_URL      3'h2
`define GW_VF_LRL      3'h3
`define GW_VF_USL      3'h4
`define GW_VF_LSL      3'h5
`define GW_VF_SPAN     3'h6
`define GW_VF_VAL      3'h7
`define GW_CTRL_RUN    0
`define GW_CTRL_APPLY  1
`define GW_CTRL_REJ    8
`define GW_DS_MORE     4
`define GW_DS_FAIL     7
`define GW_SLAVE_RST   8'h01
`define GW_UST_RST     32'h0001_0000
`define GW_MAP_RST     16'h3210
`define GW_FC_COILS    8'h01
`define GW_FC_DISC     8'h02
`define GW_FC_HOLD     8'h03
`define GW_FC_INPUT    8'h04
`define GW_QTY_VAR     16'h0002
`define GW_QTY_COIL    16'h0010
`define GW_QTY_REG     16'h0001
`define GW_CLK_HZ      25000000
`define GW_BAUD        9600
`define GW_BIT_CYC     (`GW_CLK_HZ / `GW_BAUD)
`define GW_TMO_MS      100
`define GW_TMO_CYC     (`GW_CLK_HZ / 1000 * `GW_TMO_MS)
`endif

// ==== rtl/gw_pkg.sv ====
/*
 Types shared by the gateway modules.
 Assumes gw_regs.svh is on the include path.
*/
package gw_pkg;
   typedef struct packed {
      logic [5:0]  rsv;
      logic [1:0]  order;
      logic [15:0] addr;
      logic [7:0]  func;
   } gw_cfg_s;
   typedef enum logic [1:0] {P_IDLE, P_ISSUE, P_WAIT} gw_poll_e;
   typedef enum logic [1:0] {M_IDLE, M_TX, M_RX, M_END} gw_mbst_e;
endpackage

// ==== rtl/gw_mb_if.sv ====
/*
 Request/answer carrier between the poll sequencer and the Modbus master.
 Assumes one request outstanding at a time.
*/
`timescale 1ns/1ns
`default_nettype none
interface gw_mb_if;
   logic        req;
   logic [7:0]  slave;
   logic [7:0]  func;
   logic [15:0] addr;
   logic [15:0] qty;
   logic        done;
   logic        ok;
   logic [31:0] data;
   modport ctl (output req, slave, func, addr, qty, input done, ok, data);
   modport mst (input req, slave, func, addr, qty, output done, ok, data);
endinterface
`default_nettype wire

// ==== rtl/gw_unit_conv.sv ====
/*
 Converts a device variable from its default unit to its current unit.
 Unit codes: 0 base, 1 kilo, 2 mega; other codes act as base.
*/
`timescale 1ns/1ns
`default_nettype none
module gw_unit_conv (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [31:0] val_i,
   input  wire logic [7:0]  src_unit_i,
   input  wire logic [7:0]  dst_unit_i,
   output logic      [31:0] val_o
);
   function automatic logic signed [2:0] ex(input logic [7:0] u);
      return (u < 8'h03) ? 3'(u) : 3'h0;
   endfunction

   wire logic signed [2:0]  d = ex(src_unit_i) - ex(dst_unit_i);
   wire logic signed [63:0] w = 64'($signed(val_i));
   logic signed [63:0]      r;

   // Division truncates toward zero; small values lose their fraction
   always_comb begin
      case (d)
         3'sh1:   r = w * 64'sd1000;
         3'sh2:   r = w * 64'sd1000000;
         -3'sh1:  r = w / 64'sd1000;
         -3'sh2:  r = w / 64'sd1000000;
         default: r = w;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) val_o <= 32'h0;
      else       val_o <= r[31:0];
   end
endmodule
`default_nettype wire

// ==== rtl/gw_mb_master.sv ====
/*
 Modbus-RTU master: sends one read request, collects the reply.
 Assumes 8 data bits, even parity, one stop bit; rx_i is synchronous.
*/
`timescale 1ns/1ns
`default_nettype none
`include "gw_regs.svh"
module gw_mb_master
   import gw_pkg::*;
#(
   parameter int BIT_CYC = `GW_BIT_CYC,
   parameter int TMO_CYC = `GW_TMO_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   gw_mb_if.mst      mb,
   input  wire logic rx_i,
   output logic      tx_o,
   output logic      de_o
);
   function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] x;
      x = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) x = x[0] ? ((x >> 1) ^ 16'ha001) : (x >> 1);
      return x;
   endfunction

   gw_mbst_e    st_r;
   logic [7:0]  fr_r [8];
   logic [10:0] sh_r;
   logic [2:0]  bi_r;
   logic [3:0]  bc_r, rb_r;
   logic [12:0] cyc_r, rcyc_r;
   logic [31:0] tmo_r;
   logic        ron_r, perr_r;
   logic [7:0]  rsh_r, fn_r, blen_r;
   logic [8:0]  n_r;
   logic [15:0] rcrc_r;

   wire logic [15:0] c0 = crc_b(crc_b(crc_b(16'hffff, mb.slave), mb.func), mb.addr[15:8]);
   wire logic [15:0] ctx = crc_b(crc_b(crc_b(c0, mb.addr[7:0]), mb.qty[15:8]), mb.qty[7:0]);
   wire logic [15:0] rcrc_nx = crc_b(rcrc_r, rsh_r);
   wire logic [8:0]  total = fn_r[7] ? 9'h005 : 9'({1'b0, blen_r} + 9'h005);
   wire logic        last = (n_r >= 9'h004) && (n_r + 9'h001 == total);
   wire logic        byte_end = ron_r && rcyc_r == 13'h0 && rb_r == 4'h9;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= M_IDLE; tx_o <= 1'b1; de_o <= 1'b0; mb.done <= 1'b0;
         mb.ok <= 1'b0; mb.data <= 32'h0; bi_r <= 3'h0; bc_r <= 4'h0;
         cyc_r <= 13'h0; sh_r <= 11'h7ff; tmo_r <= 32'h0;
         for (int i = 0; i < 8; i++) fr_r[i] <= 8'h00;
      end else begin
         mb.done <= 1'b0;
         case (st_r)
            M_IDLE: if (mb.req) begin
               fr_r[0] <= mb.slave; fr_r[1] <= mb.func;
               fr_r[2] <= mb.addr[15:8]; fr_r[3] <= mb.addr[7:0];
               fr_r[4] <= mb.qty[15:8]; fr_r[5] <= mb.qty[7:0];
               fr_r[6] <= ctx[7:0]; fr_r[7] <= ctx[15:8];
               sh_r <= {1'b1, ^mb.slave, mb.slave, 1'b0};
               bi_r <= 3'h0; bc_r <= 4'h0; cyc_r <= 13'h0;
               de_o <= 1'b1; st_r <= M_TX;
            end
            M_TX: if (cyc_r != 13'h0) cyc_r <= cyc_r - 13'h1;
            else if (bc_r == 4'hb) begin
               bc_r <= 4'h0;
               if (bi_r == 3'h7) begin
                  de_o <= 1'b0; tmo_r <= 32'h0; st_r <= M_RX;
               end else begin
                  bi_r <= bi_r + 3'h1;
                  sh_r <= {1'b1, ^fr_r[bi_r + 3'h1], fr_r[bi_r + 3'h1], 1'b0};
               end
            end else begin
               tx_o <= sh_r[0]; sh_r <= {1'b1, sh_r[10:1]};
               bc_r <= bc_r + 4'h1; cyc_r <= 13'(BIT_CYC - 1);
            end
            M_RX: begin
               tmo_r <= tmo_r + 32'h1;
               if (byte_end && last) begin
                  mb.ok <= rcrc_nx == 16'h0 && !perr_r && !fn_r[7];
                  mb.done <= 1'b1; st_r <= M_END;
               end else if (tmo_r == 32'(TMO_CYC - 1)) begin
                  mb.ok <= 1'b0; mb.done <= 1'b1; st_r <= M_END;
               end
               if (byte_end && n_r >= 9'h003 && n_r < 9'({1'b0, blen_r} + 9'h003))
                  mb.data <= {mb.data[23:0], rsh_r};
            end
            default: st_r <= M_IDLE;
         endcase
      end
   end

   // Receiver; stop-bit middle closes each byte
   always_ff @(posedge clk_i) begin
      if (rst_i || st_r != M_RX) begin
         ron_r <= 1'b0; rcyc_r <= 13'h0; rb_r <= 4'h0; rsh_r <= 8'h0;
         perr_r <= 1'b0; n_r <= 9'h0; rcrc_r <= 16'hffff; fn_r <= 8'h0; blen_r <= 8'h0;
      end else if (!ron_r) begin
         if (!rx_i) begin
            ron_r <= 1'b1; rb_r <= 4'h0; rcyc_r <= 13'(BIT_CYC + BIT_CYC / 2 - 1);
         end
      end else if (rcyc_r != 13'h0) rcyc_r <= rcyc_r - 13'h1;
      else begin
         rcyc_r <= 13'(BIT_CYC - 1);
         rb_r <= rb_r + 4'h1;
         if (rb_r < 4'h8) rsh_r <= {rx_i, rsh_r[7:1]};
         else if (rb_r == 4'h8) perr_r <= perr_r | (rx_i != ^rsh_r);
         else begin
            perr_r <= perr_r | !rx_i;
            ron_r <= 1'b0; n_r <= n_r + 9'h1; rcrc_r <= rcrc_nx;
            if (n_r == 9'h0) perr_r <= perr_r | !rx_i | (rsh_r != fr_r[0]);
            if (n_r == 9'h1) fn_r <= rsh_r;
            if (n_r == 9'h2) blen_r <= rsh_r;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_tx_idle_high: assert property (st_r == M_IDLE |-> tx_o && !de_o)
      else $error("tx line not idle high");
   a_timeout_fails: assert property (st_r == M_RX && tmo_r == 32'(TMO_CYC - 1)
      && !byte_end |=> mb.done && !mb.ok) else $error("timeout not reported as failure");
endmodule
`default_nettype wire

// ==== rtl/gw_top.sv ====
/*
 Modbus-to-HART variable gateway: Avalon-MM register slave, poll sequencer
 and status builder. Assumes the HART command layer reads these registers.
*/
`timescale 1ns/1ns
`default_nettype none
`include "gw_regs.svh"
module gw_top
   import gw_pkg::*;
#(
   parameter int BIT_CYC = `GW_BIT_CYC,
   parameter int TMO_CYC = `GW_TMO_CYC
) (
   input  wire logic        CLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic [8:0]  AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   input  wire logic [3:0]  AVS_BYTEENABLE_I,
   output logic      [31:0] AVS_READDATA_O,
   output logic             AVS_WAITREQUEST_O,
   input  wire logic        MB_RX_I,
   output logic             MB_TX_O,
   output logic             MB_DE_O,
   output logic      [7:0]  DEV_STATUS_O,
   output logic      [23:0] ADDL_STATUS_O
);
   function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] be);
      for (int i = 0; i < 4; i++) if (be[i]) o[8*i +: 8] = n[8*i +: 8];
      return o;
   endfunction

   function automatic logic [31:0] reorder(input logic [31:0] d, input logic [1:0] ord);
      case (ord)
         2'h1:    return {d[15:0], d[31:16]};
         2'h2:    return {d[23:16], d[31:24], d[7:0], d[15:8]};
         2'h3:    return {d[7:0], d[15:8], d[23:16], d[31:24]};
         default: return d;
      endcase
   endfunction

   function automatic logic [2:0] vsel(input logic [2:0] i);
      return (i < 3'(`GW_NVAR)) ? i : 3'h0;
   endfunction

   logic        run_r, rej_r;
   logic [15:0] sh_map_r, cm_map_r;
   logic [7:0]  sh_slave_r, cm_slave_r;
   logic [31:0] sh_ust_r, cm_ust_r;
   logic [31:0] sh_cfg_r [`GW_NVAR];
   logic [31:0] sh_unit_r [`GW_NVAR];
   logic [31:0] cm_cfg_r [`GW_NVAR];
   logic [31:0] cm_unit_r [`GW_NVAR];
   logic [31:0] url_r [`GW_NVAR];
   logic [31:0] lrl_r [`GW_NVAR];
   logic [31:0] usl_r [`GW_NVAR];
   logic [31:0] lsl_r [`GW_NVAR];
   logic [31:0] span_r [`GW_NVAR];
   logic [31:0] val_r [`GW_NVAR];
   logic [31:0] pv_val, rd_data;
   gw_poll_e    pst_r;
   logic [2:0]  idx_r;
   logic        req_r;
   logic [7:0]  fn_r;
   logic [15:0] ad_r, qty_r;

   gw_mb_if mb ();
   assign mb.req   = req_r;
   assign mb.slave = cm_slave_r;
   assign mb.func  = fn_r;
   assign mb.addr  = ad_r;
   assign mb.qty   = qty_r;

   // Bus decode
   wire logic       bus_req = AVS_READ_I | AVS_WRITE_I;
   wire logic       wr      = bus_req & ~AVS_WAITREQUEST_O & AVS_WRITE_I;
   wire logic [8:0] a       = {AVS_ADDRESS_I[8:2], 2'b00};
   wire logic       var_hit = (a >= `GW_VAR_BASE) && (a < `GW_VAR_END);
   wire logic [8:0] va      = a - `GW_VAR_BASE;
   wire logic [2:0] vn      = var_hit ? vsel(va[7:5]) : 3'h0;
   wire logic [2:0] vf      = a[4:2];
   wire logic [31:0] wv     = merge(rd_data, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
   wire logic       pv_is_vn = vn == cm_map_r[2:0];
   wire logic       in_sens = $signed(wv) <= $signed(usl_r[vn]) &&
                              $signed(wv) >= $signed(lsl_r[vn]);
   wire logic       rng_wr  = wr && var_hit && (vf == `GW_VF_URL || vf == `GW_VF_LRL);
   wire logic       rng_ok  = pv_is_vn && in_sens;
   wire logic       map_ok  = wv[2:0] < 3'h6 && wv[6:4] < 3'h6 && wv[10:8] < 3'h6 &&
                              wv[14:12] < 3'h6;
   wire logic       map_wr  = wr && a == `GW_MAP_OFS;
   wire logic       ctrl_wr = wr && a == `GW_CTRL_OFS;
   wire logic       apply   = ctrl_wr && wv[`GW_CTRL_APPLY];
   wire logic       rej_set = (rng_wr && !rng_ok) || (map_wr && !map_ok);
   wire logic [31:0] url_cur = url_r[vn];
   wire logic [31:0] lrl_cur = lrl_r[vn];

   always_comb begin
      rd_data = 32'h0;
      if (a == `GW_CTRL_OFS) rd_data = {23'h0, rej_r, 7'h0, run_r};
      else if (a == `GW_MAP_OFS) rd_data = {16'h0, sh_map_r};
      else if (a == `GW_ADDL_OFS) rd_data = {8'h0, ADDL_STATUS_O};
      else if (a == `GW_PV_OFS) rd_data = pv_val;
      else if (a == `GW_MB_OFS) rd_data = {24'h0, sh_slave_r};
      else if (a == `GW_UST_OFS) rd_data = sh_ust_r;
      else if (a == `GW_RESP_OFS) rd_data = {16'h0, DEV_STATUS_O, 8'h00};
      else if (var_hit) begin
         if (vf == `GW_VF_CFG) rd_data = sh_cfg_r[vn];
         else if (vf == `GW_VF_UNIT) rd_data = sh_unit_r[vn];
         else if (vf == `GW_VF_URL) rd_data = url_r[vn];
         else if (vf == `GW_VF_LRL) rd_data = lrl_r[vn];
         else if (vf == `GW_VF_USL) rd_data = usl_r[vn];
         else if (vf == `GW_VF_LSL) rd_data = lsl_r[vn];
         else if (vf == `GW_VF_SPAN) rd_data = span_r[vn];
         else rd_data = val_r[vn];
      end
   end

   // One wait cycle per access; the answer stands in the cycle waitrequest is low
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         AVS_WAITREQUEST_O <= 1'b1;
         AVS_READDATA_O    <= 32'h0;
      end else if (bus_req && AVS_WAITREQUEST_O) begin
         AVS_WAITREQUEST_O <= 1'b0;
         AVS_READDATA_O    <= rd_data;
      end else AVS_WAITREQUEST_O <= 1'b1;
   end

   // Configuration storage; shadow copies reach the poller only on apply
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         run_r <= 1'b0; rej_r <= 1'b0;
         sh_map_r <= `GW_MAP_RST; cm_map_r <= `GW_MAP_RST;
         sh_slave_r <= `GW_SLAVE_RST; cm_slave_r <= `GW_SLAVE_RST;
         sh_ust_r <= `GW_UST_RST; cm_ust_r <= `GW_UST_RST;
         for (int i = 0; i < `GW_NVAR; i++) begin
            sh_cfg_r[i] <= 32'h0; sh_unit_r[i] <= 32'h0;
            cm_cfg_r[i] <= 32'h0; cm_unit_r[i] <= 32'h0;
            url_r[i] <= 32'h0; lrl_r[i] <= 32'h0; usl_r[i] <= 32'h0;
            lsl_r[i] <= 32'h0; span_r[i] <= 32'h0;
         end
      end else begin
         rej_r <= rej_set | (rej_r & ~(ctrl_wr & wv[`GW_CTRL_REJ]));
         if (ctrl_wr) run_r <= wv[`GW_CTRL_RUN];
         if (apply) begin
            cm_map_r <= sh_map_r; cm_slave_r <= sh_slave_r; cm_ust_r <= sh_ust_r;
            for (int i = 0; i < `GW_NVAR; i++) begin
               cm_cfg_r[i] <= sh_cfg_r[i];
               cm_unit_r[i] <= sh_unit_r[i];
            end
         end
         if (map_wr && map_ok) sh_map_r <= wv[15:0];
         if (wr && a == `GW_MB_OFS) sh_slave_r <= wv[7:0];
         if (wr && a == `GW_UST_OFS) sh_ust_r <= {8'h0, wv[23:0]};
         if (wr && var_hit) begin
            if (vf == `GW_VF_CFG) sh_cfg_r[vn] <= wv;
            else if (vf == `GW_VF_UNIT) sh_unit_r[vn] <= wv;
            else if (vf == `GW_VF_URL && rng_ok) url_r[vn] <= wv;
            else if (vf == `GW_VF_LRL && rng_ok) lrl_r[vn] <= wv;
            else if (vf == `GW_VF_USL) usl_r[vn] <= wv;
            else if (vf == `GW_VF_LSL) lsl_r[vn] <= wv;
            else if (vf == `GW_VF_SPAN) span_r[vn] <= wv;
         end
      end
   end

   // Poll sequencer: six variables, then the user status register
   wire logic [2:0]  ix     = vsel(idx_r);
   wire gw_cfg_s     ccfg   = gw_cfg_s'(cm_cfg_r[ix]);
   wire logic        is_st  = idx_r == 3'(`GW_NVAR);
   wire logic [7:0]  nfn    = is_st ? cm_ust_r[23:16] : ccfg.func;
   wire logic [15:0] nadr   = (is_st ? cm_ust_r[15:0] : ccfg.addr) - 16'h0001;
   wire logic        coil   = nfn == `GW_FC_COILS || nfn == `GW_FC_DISC;
   wire logic [15:0] nqty   = is_st ? (coil ? `GW_QTY_COIL : `GW_QTY_REG) : `GW_QTY_VAR;
   wire logic        fbad   = ccfg.func != `GW_FC_HOLD && ccfg.func != `GW_FC_INPUT;
   wire logic        nbad   = is_st ? cm_ust_r[15:0] == 16'h0 : (fbad || ccfg.addr == 16'h0);
   wire logic [2:0]  idx_nx = is_st ? 3'h0 : idx_r + 3'h1;
   wire logic [15:0] ust16  = (fn_r == `GW_FC_COILS || fn_r == `GW_FC_DISC) ?
                              {mb.data[7:0], mb.data[15:8]} : mb.data[15:0];
   wire logic        ans    = pst_r == P_WAIT && mb.done;
   wire logic [7:0]  ds_nx  = {&ADDL_STATUS_O[5:0], 2'b00, |ADDL_STATUS_O, 4'h0};

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         pst_r <= P_IDLE; idx_r <= 3'h0; req_r <= 1'b0;
         fn_r <= 8'h0; ad_r <= 16'h0; qty_r <= 16'h0;
         ADDL_STATUS_O <= 24'h0; DEV_STATUS_O <= 8'h0;
         for (int i = 0; i < `GW_NVAR; i++) val_r[i] <= 32'h0;
      end else begin
         req_r <= 1'b0;
         DEV_STATUS_O <= {ds_nx[7], 2'b00, ds_nx[4], 4'h0};
         case (pst_r)
            P_IDLE: if (run_r) pst_r <= P_ISSUE;
            P_ISSUE: if (!run_r) pst_r <= P_IDLE;
            else if (nbad) begin
               if (!is_st) ADDL_STATUS_O[ix] <= 1'b1;
               idx_r <= idx_nx;
            end else begin
               req_r <= 1'b1; fn_r <= nfn; ad_r <= nadr; qty_r <= nqty;
               pst_r <= P_WAIT;
            end
            P_WAIT: if (mb.done) begin
               if (!is_st) begin
                  if (mb.ok) val_r[ix] <= reorder(mb.data, ccfg.order);
                  ADDL_STATUS_O[ix] <= !mb.ok;
               end else if (mb.ok) ADDL_STATUS_O[23:8] <= ust16;
               idx_r <= idx_nx;
               pst_r <= P_ISSUE;
            end
            default: pst_r <= P_IDLE;
         endcase
      end
   end

   gw_unit_conv u_conv (
      .clk_i      (CLK_I),
      .rst_i      (SYS_RST_I),
      .val_i      (val_r[vsel(cm_map_r[2:0])]),
      .src_unit_i (cm_unit_r[vsel(cm_map_r[2:0])][15:8]),
      .dst_unit_i (cm_unit_r[vsel(cm_map_r[2:0])][7:0]),
      .val_o      (pv_val)
   );

   gw_mb_master #(.BIT_CYC(BIT_CYC), .TMO_CYC(TMO_CYC)) u_mb (
      .clk_i (CLK_I),
      .rst_i (SYS_RST_I),
      .mb    (mb),
      .rx_i  (MB_RX_I),
      .tx_o  (MB_TX_O),
      .de_o  (MB_DE_O)
   );

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   sequence s_bus_wait;
      bus_req && AVS_WAITREQUEST_O;
   endsequence
   sequence s_bus_answer;
      !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
   endsequence
   a_bus_one_wait: assert property (s_bus_wait |=> s_bus_answer)
      else $error("bus answer not one cycle after request");
   a_cfg_no_poll: assert property (!$past(run_r) |-> !req_r)
      else $error("poll started in configuration mode");
   a_addr_minus_one: assert property (req_r && !is_st |-> ad_r + 16'h1 == ccfg.addr)
      else $error("request address not configured minus one");
   a_func_used: assert property (req_r && !is_st |-> fn_r == ccfg.func &&
      qty_r == `GW_QTY_VAR) else $error("variable request uses wrong function");
   a_fail_flag: assert property (ans && !mb.ok && !is_st |=> ADDL_STATUS_O[$past(ix)])
      else $error("failed read not flagged");
   a_range_gate: assert property (rng_wr && !pv_is_vn |=> rej_r &&
      url_r[$past(vn)] == $past(url_cur) && lrl_r[$past(vn)] == $past(lrl_cur))
      else $error("range write accepted for non-primary variable");
   a_apply_commit: assert property (apply |=> cm_map_r == $past(sh_map_r) &&
      cm_ust_r == $past(sh_ust_r)) else $error("apply did not commit");
   a_ust_bytes: assert property (ans && mb.ok && is_st |=>
      ADDL_STATUS_O[15:8] == $past(ust16[7:0]) && ADDL_STATUS_O[23:16] == $past(ust16[15:8]))
      else $error("user status bytes misplaced");
   a_resp_byte: assert property (s_bus_wait ##0 (a == `GW_RESP_OFS) |=>
      AVS_READDATA_O[15:8] == $past(DEV_STATUS_O)) else $error("status byte not second");
   a_poll_wrap: assert property (ans && is_st |=> idx_r == 3'h0 && pst_r == P_ISSUE)
      else $error("poll cycle did not wrap to variable zero");
endmodule
`default_nettype wire

// ==== testbench/gw_board_model.sv ====
/* Modbus user-board model: answers each read request while answer_i is high.
 Assumes 8E1 framing at BIT_CYC clocks a bit. */
`timescale 1ns/1ns
`default_nettype none
module gw_board_model #(parameter int BIT_CYC = 8) (
   input  wire logic        clk_i,
   input  wire logic        tx_i,
   input  wire logic        answer_i,
   output logic             rx_o,
   output logic      [7:0]  func_o,
   output logic      [15:0] addr_o
);
   logic [7:0]  q [12];
   logic [15:0] crc;
   int          n;
   task automatic bit_out(input logic b);
      rx_o <= b;
      repeat (BIT_CYC) @(posedge clk_i);
   endtask
   initial begin
      rx_o = 1'b1;
      forever begin
         for (int k = 0; k < 8; k++) begin
            @(negedge tx_i);
            repeat (BIT_CYC * 3 / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
               q[k][i] = tx_i;
               repeat (BIT_CYC) @(posedge clk_i);
            end
         end
         func_o = q[1];
         addr_o = {q[2], q[3]};
         n = (q[1] < 8'h03) ? q[5] / 8 : q[5] * 2;
         q[2] = n[7:0];
         for (int i = 0; i < n; i++) q[3+i] = 8'(8'h11 * (i + 1));
         crc = 16'hffff;
         for (int i = 0; i < n + 3; i++) begin
            crc ^= {8'h00, q[i]};
            repeat (8) crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
         end
         {q[n+4], q[n+3]} = crc;
         if (answer_i) begin
            repeat (4 * BIT_CYC) @(posedge clk_i);
            for (int k = 0; k < n + 5; k++) begin
               bit_out(1'b0);
               for (int i = 0; i < 8; i++) bit_out(q[k][i]);
               bit_out(^q[k]);
               bit_out(1'b1);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/modbus_hart_variable_gateway_bench.sv ====
/* Bench for gw_top: register tasks, board model, status checks.
 Assumes a one-cycle register answer and shortened bit and timeout counts. */
`timescale 1ns/1ns
`default_nettype none
module modbus_hart_variable_gateway_bench;
   logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, answer = 1'b1, quiet = 1'b1;
   logic        tx, de, rx, wreq;
   logic        de_err = 1'b0;
   logic [8:0]  adr = '0;
   logic [31:0] wdat = '0, rdat, q;
   logic [7:0]  dev, func;
   logic [15:0] addr;
   logic [23:0] addl;
   int          n_fail = 0, check_count = 0;
   gw_top #(.BIT_CYC(8), .TMO_CYC(2000)) u_gw_top (.CLK_I(clk), .SYS_RST_I(rst),
      .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
      .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
      .MB_RX_I(rx), .MB_TX_O(tx), .MB_DE_O(de), .DEV_STATUS_O(dev), .ADDL_STATUS_O(addl));
   gw_board_model #(.BIT_CYC(8)) u_gw_board_model (.clk_i(clk), .tx_i(tx),
      .answer_i(answer), .rx_o(rx), .func_o(func), .addr_o(addr));
   always #20 clk = ~clk;
   task automatic end_sim();
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   // Gap cycle first, so a strobe is never reassigned in one step
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      n = 0;
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 50) begin
         n_fail++;
         $display("unexpected waitrequest exp 0 got 1");
         end_sim();
      end
   endtask
   task automatic rdc(input logic [8:0] a, input string nm, input logic [31:0] e);
      bus(1'b0, a, '0);
      chk(nm, e, q);
   endtask
   task automatic wait_addl(input logic [23:0] m, input logic [23:0] v);
      int n;
      for (n = 0; n < 30000 && (addl & m) !== v; n++) @(posedge clk);
      if (n >= 30000) begin
         n_fail++;
         $display("unexpected addl exp %h got %h", v, addl & m);
         end_sim();
      end
   endtask
   always @(posedge clk) if (quiet && de === 1'b1 && !de_err) begin
      n_fail++;
      de_err <= 1'b1;
      $display("unexpected MB_DE_O exp 0 got 1");
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (200) @(posedge clk);
      rdc(9'h004, "map", 32'h3210);
      rdc(9'h1fc, "unmapped", 0);
      bus(1, 9'h050, 32'd100);
      bus(1, 9'h058, 32'd1);
      rdc(9'h058, "span0", 32'd1);
      bus(1, 9'h048, 32'd60);
      rdc(9'h048, "url0", 32'd60);
      bus(1, 9'h070, 32'd100);
      bus(1, 9'h068, 32'd60);
      rdc(9'h000, "ctrl", 32'h100);
      rdc(9'h068, "url1", 0);
      bus(1, 9'h000, 32'h100);
      bus(1, 9'h004, 32'h6210);
      rdc(9'h000, "badmap", 32'h100);
      bus(1, 9'h040, 32'h0075_3103);
      bus(1, 9'h060, 32'h0100_0204);
      bus(1, 9'h064, 32'h0000_0001);
      bus(1, 9'h080, 32'h0200_0103);
      bus(1, 9'h0a0, 32'h0300_0104);
      bus(1, 9'h014, 32'h0001_0011);
      bus(1, 9'h004, 32'h3201);
      bus(1, 9'h000, 32'h2);
      quiet <= 1'b0;
      bus(1, 9'h000, 32'h1);
      wait_addl(24'hffffff, 24'h221130);
      chk("func", 1, func);
      chk("addr", 16'h0010, addr);
      rdc(9'h05c, "val0", 32'h11223344);
      rdc(9'h07c, "val1", 32'h33441122);
      rdc(9'h09c, "val2", 32'h22114433);
      rdc(9'h0bc, "val3", 32'h44332211);
      rdc(9'h00c, "pv", 32'h000d1fc2);
      rdc(9'h008, "addl", 32'h221130);
      chk("dev", 8'h10, dev);
      rdc(9'h018, "resp", 32'h1000);
      answer <= 1'b0;
      wait_addl(24'h00003f, 24'h00003f);
      @(posedge clk);
      chk("devfail", 8'h90, dev);
      bus(1, 9'h000, 32'h0);
      repeat (3000) @(posedge clk);
      quiet <= 1'b1;
      repeat (3000) @(posedge clk);
      end_sim();
   end
endmodule
`default_nettype wire
